// ===== hw/io_pkg.sv
// Constants, types and register map of the rear connector control block
// What this block does
// RULE1: Enable function off: ignore enable contact and polarity, never gate output.
// RULE2: Enable on, normal polarity: open/high input forces output off, low allows.
// RULE3: Polarity setting reverses enable gating: open/high allows, low forces off.
// RULE4: Interlock function off: ignore interlock contact, never gate output.
// RULE5: Interlock on: open/high input forces output off, low allows; no polarity.
// RULE6: Each programmable pin is static low, static high or configurable pulse train.
// RULE7: External equipment pulses measurement trigger input when it is selected source.
// RULE8: Trigger output is active high, produced by one of three selectable modes.
// RULE9: Mains good pin pulled low without mains fault, released during a fault.
// RULE10: Alarm pin released on any fault or output off, pulled low otherwise.
// RULE11: Every fault sets its bit in the fault event register.
// RULE12: While a fault persists, alarm indicator blinks at 1 Hz and output is disabled.
// RULE13: Output on only if both gates permit; contact inputs synchronised first.
package io_pkg;

  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned BLINK_PERIOD_MS = 1000;
  localparam int unsigned BLINK_HALF_CYCLES = BLINK_PERIOD_MS * 1_000_000 / 2 / CLK_PERIOD_NS;
  localparam int unsigned BLINK_W = 26;

  ////////////////////////////////////////////////////////////////////////////
  localparam logic [11:0] CTRL_OFFSET = 12'h000;
  localparam logic [11:0] STATUS_OFFSET = 12'h004;
  localparam logic [11:0] FAULT_OFFSET = 12'h008;
  localparam logic [11:0] IRQ_STATUS_OFFSET = 12'h00C;
  localparam logic [11:0] IRQ_MASK_OFFSET = 12'h010;
  localparam logic [11:0] PIN_BASE_OFFSET = 12'h014;
  localparam logic [11:0] PIN_STRIDE = 12'h00C;
  localparam logic [11:0] PIN_CFG_OFFSET = 12'h000;
  localparam logic [11:0] PIN_PERIOD_OFFSET = 12'h004;
  localparam logic [11:0] PIN_HIGH_OFFSET = 12'h008;

  localparam int unsigned CTRL_OUT_REQ = 0;
  localparam int unsigned CTRL_ENA_FUNC = 1;
  localparam int unsigned CTRL_ENA_REV = 2;
  localparam int unsigned CTRL_LOOP_FUNC = 3;
  localparam int unsigned CTRL_TRIG_MODE = 4;
  localparam int unsigned CTRL_MEAS_SEL = 6;
  localparam int unsigned CTRL_W = 7;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 7'h00;

  localparam int unsigned PIN_CFG_MODE = 0;
  localparam int unsigned PIN_CFG_COUNT = 16;

  localparam int unsigned FAULT_W = 8;
  localparam int unsigned FAULT_MAINS = 0;
  localparam int unsigned IRQ_MEAS = 8;
  localparam int unsigned IRQ_SHUTDOWN = 9;
  localparam int unsigned IRQ_W = 10;
  localparam logic [IRQ_W-1:0] IRQ_RESET = 10'h000;

  localparam int unsigned SYNC_ENA = 0;
  localparam int unsigned SYNC_LOOP = 1;
  localparam int unsigned SYNC_TRIG = 2;
  localparam int unsigned SYNC_GP0 = 3;
  localparam int unsigned SYNC_MAINS = 5;
  localparam int unsigned SYNC_ALARM = 6;
  localparam int unsigned SYNC_W = 7;

  typedef enum logic [1:0] {PIN_LOW, PIN_HIGH, PIN_PULSE} pin_mode_type;
  typedef enum logic [1:0] {TRIG_DATA_READY, TRIG_OUTPUT_ON, TRIG_MEAS_START} trig_mode_type;

endpackage

// ===== hw/pin_pulser.sv
// Static level or pulse train generator for one programmable pin
`timescale 1ns/100ps
module pin_pulser
  import io_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic [1:0] mode,
  input wire logic [15:0] period,
  input wire logic [15:0] high_time,
  input wire logic [15:0] count,
  input wire logic start,
  output logic level,
  output logic busy
);

  typedef struct packed {
    logic [15:0] phase;
    logic [15:0] left;
    logic active;
    logic level;
  } pulse_state_type;

  pulse_state_type q;
  pulse_state_type next_q;

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    next_q = q;
    if (start) begin
      next_q.phase = 16'h0000;
      next_q.left = count;
      next_q.active = (mode == PIN_PULSE);
    end else if (q.active) begin
      // Period of zero behaves as one cycle
      if (q.phase + 16'h0001 >= period) begin
        next_q.phase = 16'h0000;
        // Count of zero runs without end
        if (q.left == 16'h0001) begin
          next_q.active = 1'b0;
        end
        if (q.left != 16'h0000) begin
          next_q.left = q.left - 16'h0001;
        end
      end else begin
        next_q.phase = q.phase + 16'h0001;
      end
    end
    case (pin_mode_type'(mode))
      PIN_LOW: next_q.level = 1'b0; // RULE6
      PIN_HIGH: next_q.level = 1'b1; // RULE6
      PIN_PULSE: next_q.level = next_q.active && (next_q.phase < high_time); // RULE6
      default: next_q.level = 1'b0;
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end

  assign level = q.level;
  assign busy = q.active;

endmodule

// ===== hw/output_gate_io.sv
// Output gating, status pins, triggers, programmable pins and APB registers
`timescale 1ns/100ps
module output_gate_io
  import io_pkg::*;
#(
  parameter int unsigned BLINK_HALF = BLINK_HALF_CYCLES
)
(
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic enable_gate_input,
  input wire logic safety_loop_input,
  input wire logic meas_trig_input,
  input wire logic [1:0] gp_pin_in,
  output logic [1:0] gp_pin_out,
  output logic [1:0] gp_pin_oe_b,
  input wire logic mains_good_output_in,
  output logic mains_good_output_out,
  output logic mains_good_output_oe_b,
  input wire logic alarm_output_in,
  output logic alarm_output_out,
  output logic alarm_output_oe_b,
  output logic trig_output,
  input wire logic [FAULT_W-1:0] fault_in,
  input wire logic meas_done,
  output logic meas_start,
  output logic output_on,
  output logic alarm_led,
  output logic irq
);

  typedef struct packed {
    logic [SYNC_W-1:0] sync1;
    logic [SYNC_W-1:0] sync2;
    logic trig_prev;
    logic [CTRL_W-1:0] ctrl;
    logic [IRQ_W-1:0] irq_stat;
    logic [IRQ_W-1:0] irq_mask;
    logic [1:0][1:0] pin_mode;
    logic [1:0][15:0] pin_count;
    logic [1:0][15:0] pin_period;
    logic [1:0][15:0] pin_high;
    logic [1:0] pin_start;
    logic [FAULT_W-1:0] fault_prev;
    logic output_on;
    logic alarm_pull;
    logic mains_pull;
    logic alarm_led;
    logic trig_out;
    logic meas_start;
    logic [BLINK_W-1:0] blink_cnt;
    logic [31:0] prdata;
  } state_type;

  state_type q;
  state_type next_q;
  logic [1:0] pin_level;
  logic [1:0] pin_busy;
  logic fault_present;
  logic ena_ok;
  logic loop_ok;
  logic trig_rise;
  logic setup;
  logic access;
  logic mapped;

  // Gate passes when its function is off, else when contact level matches polarity
  function automatic logic gate_ok(input logic func_on, input logic contact_high, input logic reverse);
    gate_ok = !func_on || (contact_high ^ !reverse);
  endfunction

  function automatic logic [11:0] pin_addr(input int unsigned pin, input logic [11:0] offset);
    pin_addr = PIN_BASE_OFFSET + 12'(pin) * PIN_STRIDE + offset;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  for (genvar i = 0; i < 2; i++) begin : g_pin
    pin_pulser u_pulser (
      .ref_clk(ref_clk),
      .rst_b(rst_b),
      .mode(q.pin_mode[i]),
      .period(q.pin_period[i]),
      .high_time(q.pin_high[i]),
      .count(q.pin_count[i]),
      .start(q.pin_start[i]),
      .level(pin_level[i]),
      .busy(pin_busy[i])
    );
  end

  ////////////////////////////////////////////////////////////////////////////
  assign fault_present = |fault_in;
  assign ena_ok = gate_ok(q.ctrl[CTRL_ENA_FUNC], q.sync2[SYNC_ENA], q.ctrl[CTRL_ENA_REV]); // RULE1 RULE2 RULE3
  assign loop_ok = gate_ok(q.ctrl[CTRL_LOOP_FUNC], q.sync2[SYNC_LOOP], 1'b0); // RULE4 RULE5
  assign trig_rise = q.sync2[SYNC_TRIG] && !q.trig_prev;
  assign setup = psel && !penable;
  assign access = psel && penable;

  always_comb begin
    mapped = (paddr == CTRL_OFFSET) || (paddr == STATUS_OFFSET) || (paddr == FAULT_OFFSET) ||
             (paddr == IRQ_STATUS_OFFSET) || (paddr == IRQ_MASK_OFFSET);
    for (int i = 0; i < 2; i++) begin
      if ((paddr == pin_addr(i, PIN_CFG_OFFSET)) || (paddr == pin_addr(i, PIN_PERIOD_OFFSET)) ||
          (paddr == pin_addr(i, PIN_HIGH_OFFSET))) begin
        mapped = 1'b1;
      end
    end
  end

  always_comb begin
    next_q = q;
    // Pins pass two flops before any logic looks at them
    next_q.sync1 = {alarm_output_in, mains_good_output_in, gp_pin_in, meas_trig_input, safety_loop_input,
                    enable_gate_input}; // RULE13
    next_q.sync2 = q.sync1; // RULE13
    next_q.trig_prev = q.sync2[SYNC_TRIG];
    next_q.fault_prev = fault_in;
    next_q.pin_start = 2'b00;

    next_q.output_on = q.ctrl[CTRL_OUT_REQ] && ena_ok && loop_ok && !fault_present; // RULE13 RULE12
    next_q.mains_pull = !fault_in[FAULT_MAINS]; // RULE9
    next_q.alarm_pull = !fault_present && q.output_on; // RULE10

    // Blink toggles every half second while any fault stands
    if (!fault_present) begin
      next_q.blink_cnt = '0;
      next_q.alarm_led = 1'b0;
    end else if (q.blink_cnt == BLINK_W'(BLINK_HALF - 1)) begin
      next_q.blink_cnt = '0;
      next_q.alarm_led = !q.alarm_led; // RULE12
    end else begin
      next_q.blink_cnt = q.blink_cnt + 1'b1;
    end

    next_q.meas_start = trig_rise && q.ctrl[CTRL_MEAS_SEL]; // RULE7
    case (trig_mode_type'(q.ctrl[CTRL_TRIG_MODE +: 2]))
      TRIG_DATA_READY: next_q.trig_out = meas_done; // RULE8
      TRIG_OUTPUT_ON: next_q.trig_out = q.output_on; // RULE8
      TRIG_MEAS_START: next_q.trig_out = q.meas_start; // RULE8
      default: next_q.trig_out = 1'b0;
    endcase

    // Read data captured in setup so it comes from a flop
    if (setup) begin
      next_q.prdata = 32'h0000_0000;
      case (paddr)
        CTRL_OFFSET: next_q.prdata[CTRL_W-1:0] = q.ctrl;
        STATUS_OFFSET: next_q.prdata[SYNC_W+6:0] = {q.sync2, pin_busy, q.alarm_led, fault_present,
                                                    loop_ok, ena_ok, q.output_on};
        FAULT_OFFSET: next_q.prdata[FAULT_W-1:0] = fault_in;
        IRQ_STATUS_OFFSET: next_q.prdata[IRQ_W-1:0] = q.irq_stat;
        IRQ_MASK_OFFSET: next_q.prdata[IRQ_W-1:0] = q.irq_mask;
        default: begin
          for (int i = 0; i < 2; i++) begin
            if (paddr == pin_addr(i, PIN_CFG_OFFSET)) begin
              next_q.prdata = {q.pin_count[i], 14'h0000, q.pin_mode[i]};
            end
            if (paddr == pin_addr(i, PIN_PERIOD_OFFSET)) begin
              next_q.prdata[15:0] = q.pin_period[i];
            end
            if (paddr == pin_addr(i, PIN_HIGH_OFFSET)) begin
              next_q.prdata[15:0] = q.pin_high[i];
            end
          end
        end
      endcase
    end

    if (access && pwrite) begin
      case (paddr)
        CTRL_OFFSET: next_q.ctrl = pwdata[CTRL_W-1:0];
        IRQ_STATUS_OFFSET: next_q.irq_stat = q.irq_stat & ~pwdata[IRQ_W-1:0];
        IRQ_MASK_OFFSET: next_q.irq_mask = pwdata[IRQ_W-1:0];
        default: begin
          for (int i = 0; i < 2; i++) begin
            if (paddr == pin_addr(i, PIN_CFG_OFFSET)) begin
              next_q.pin_mode[i] = pwdata[PIN_CFG_MODE +: 2];
              next_q.pin_count[i] = pwdata[PIN_CFG_COUNT +: 16];
              next_q.pin_start[i] = 1'b1;
            end
            if (paddr == pin_addr(i, PIN_PERIOD_OFFSET)) begin
              next_q.pin_period[i] = pwdata[15:0];
            end
            if (paddr == pin_addr(i, PIN_HIGH_OFFSET)) begin
              next_q.pin_high[i] = pwdata[15:0];
            end
          end
        end
      endcase
    end

    // Events set after the clear so a same-cycle event is never lost
    next_q.irq_stat[FAULT_W-1:0] = next_q.irq_stat[FAULT_W-1:0] | (fault_in & ~q.fault_prev); // RULE11
    next_q.irq_stat[IRQ_MEAS] = next_q.irq_stat[IRQ_MEAS] | q.meas_start;
    next_q.irq_stat[IRQ_SHUTDOWN] = next_q.irq_stat[IRQ_SHUTDOWN] | (q.output_on && !next_q.output_on);
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  assign prdata = q.prdata;
  assign pready = access;
  assign pslverr = access && !mapped;
  assign gp_pin_out = 2'b00;
  assign gp_pin_oe_b = pin_level; // RULE6
  assign mains_good_output_out = 1'b0;
  assign mains_good_output_oe_b = !q.mains_pull; // RULE9
  assign alarm_output_out = 1'b0;
  assign alarm_output_oe_b = !q.alarm_pull; // RULE10
  assign trig_output = q.trig_out; // RULE8
  assign meas_start = q.meas_start;
  assign output_on = q.output_on;
  assign alarm_led = q.alarm_led;
  assign irq = |(q.irq_stat & q.irq_mask);

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_b);

  sequence enable_blocks_s;
    q.ctrl[CTRL_ENA_FUNC] && !q.ctrl[CTRL_ENA_REV] && q.sync2[SYNC_ENA];
  endsequence

  sequence loop_blocks_s;
    q.ctrl[CTRL_LOOP_FUNC] && q.sync2[SYNC_LOOP];
  endsequence

  ena_ignored_a: assert property (!q.ctrl[CTRL_ENA_FUNC] && q.ctrl[CTRL_OUT_REQ] && loop_ok && !fault_present
    |=> q.output_on) else $error("Output held off by disabled enable gate"); // RULE1
  ena_normal_a: assert property (enable_blocks_s |=> !q.output_on)
    else $error("Output on with open enable input"); // RULE2
  ena_reverse_a: assert property (q.ctrl[CTRL_ENA_FUNC] && q.ctrl[CTRL_ENA_REV] && !q.sync2[SYNC_ENA]
    |=> !q.output_on) else $error("Reverse polarity did not block"); // RULE3
  loop_ignored_a: assert property (!q.ctrl[CTRL_LOOP_FUNC] && q.ctrl[CTRL_OUT_REQ] && ena_ok && !fault_present
    |=> q.output_on) else $error("Output held off by disabled interlock"); // RULE4
  loop_open_a: assert property (loop_blocks_s |=> !q.output_on)
    else $error("Output on with open interlock"); // RULE5
  pin_static_a: assert property (q.pin_mode[0] == PIN_LOW && $stable(q.pin_mode[0]) [*2] |-> gp_pin_oe_b[0] == 1'b0)
    else $error("Static low pin not driven"); // RULE6
  trig_level_a: assert property (q.ctrl[CTRL_TRIG_MODE +: 2] == 2'h1 && $stable(q.ctrl) |=> trig_output == $past(q.output_on))
    else $error("Trigger out does not follow output"); // RULE8
  mains_pin_a: assert property (fault_in[FAULT_MAINS] |=> mains_good_output_oe_b)
    else $error("Mains good pulled during mains fault"); // RULE9
  alarm_pin_a: assert property (!alarm_output_oe_b |-> $past(q.output_on) && !$past(fault_present))
    else $error("Alarm pulled during fault or off"); // RULE10
  fault_event_a: assert property (fault_in[1] && !q.fault_prev[1] |=> q.irq_stat[1])
    else $error("Fault event bit not set"); // RULE11
  fault_off_a: assert property (fault_present ##1 fault_present |-> !q.output_on)
    else $error("Output on during fault"); // RULE12
  blink_a: assert property (fault_present && q.blink_cnt == BLINK_W'(BLINK_HALF - 1) |=>
    q.alarm_led != $past(q.alarm_led)) else $error("Alarm indicator missed toggle"); // RULE12
  sync_path_a: assert property (q.sync2 == $past(q.sync1))
    else $error("Contact synchroniser broken"); // RULE13

endmodule

// ===== verification/contact_model.sv
// External contacts and pull-up resolution of the open-drain status lines
`timescale 1ns/100ps
module contact_model (
  input wire logic ena_open,
  input wire logic loop_open,
  input wire logic trig_cmd,
  input wire logic [1:0] gp_pin_out,
  input wire logic [1:0] gp_pin_oe_b,
  input wire logic mains_good_output_out,
  input wire logic mains_good_output_oe_b,
  input wire logic alarm_output_out,
  input wire logic alarm_output_oe_b,
  output logic enable_gate_input,
  output logic safety_loop_input,
  output logic meas_trig_input,
  output logic [1:0] gp_pin_in,
  output logic mains_good_output_in,
  output logic alarm_output_in
);
  ////////////////////////////////////////
  // Open contact reads high through its pull-up
  assign enable_gate_input = ena_open;
  assign safety_loop_input = loop_open;
  // Trigger held several cycles so the synchroniser cannot miss it
  assign meas_trig_input = trig_cmd;
  ////////////////////////////////////////
  // Released line floats to the pull-up, driven line shows the driver
  assign gp_pin_in = gp_pin_oe_b | gp_pin_out;
  assign mains_good_output_in = mains_good_output_oe_b | mains_good_output_out;
  assign alarm_output_in = alarm_output_oe_b | alarm_output_out;
endmodule

// ===== verification/output_gate_io_tb.sv
// Self-checking bench for the rear connector control block
`timescale 1ns/100ps
module output_gate_io_tb
  import io_pkg::*;
;
  localparam int HALF = 4;
  logic ref_clk = 1'b0;
  logic rst_b = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [7:0] fault_in = 8'h00;
  logic meas_done = 1'b0, ena_open = 1'b0, loop_open = 1'b0, trig_cmd = 1'b0;
  logic [31:0] prdata;
  logic pready, pslverr, enable_gate_input, safety_loop_input, meas_trig_input;
  logic [1:0] gp_pin_in, gp_pin_out, gp_pin_oe_b;
  logic mains_good_output_in, mains_good_output_out, mains_good_output_oe_b;
  logic alarm_output_in, alarm_output_out, alarm_output_oe_b;
  logic trig_output, meas_start, output_on, alarm_led, irq;
  logic [32:0] rq[$];
  logic [32:0] note;
  logic [7:0] f;
  logic [31:0] r;
  int c[5];
  int n_fail = 0;
  int compares = 0;
  int seed = 32'h3e3d_94f3;
  int cyc = 0;

  always #5 ref_clk = ~ref_clk;

  output_gate_io #(.BLINK_HALF(HALF)) dut (
    .ref_clk(ref_clk), .rst_b(rst_b), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .enable_gate_input(enable_gate_input), .safety_loop_input(safety_loop_input),
    .meas_trig_input(meas_trig_input), .gp_pin_in(gp_pin_in), .gp_pin_out(gp_pin_out),
    .gp_pin_oe_b(gp_pin_oe_b), .mains_good_output_in(mains_good_output_in),
    .mains_good_output_out(mains_good_output_out), .mains_good_output_oe_b(mains_good_output_oe_b),
    .alarm_output_in(alarm_output_in), .alarm_output_out(alarm_output_out),
    .alarm_output_oe_b(alarm_output_oe_b), .trig_output(trig_output), .fault_in(fault_in),
    .meas_done(meas_done), .meas_start(meas_start), .output_on(output_on), .alarm_led(alarm_led), .irq(irq));

  contact_model far (
    .ena_open(ena_open), .loop_open(loop_open), .trig_cmd(trig_cmd), .gp_pin_out(gp_pin_out),
    .gp_pin_oe_b(gp_pin_oe_b), .mains_good_output_out(mains_good_output_out),
    .mains_good_output_oe_b(mains_good_output_oe_b), .alarm_output_out(alarm_output_out),
    .alarm_output_oe_b(alarm_output_oe_b), .enable_gate_input(enable_gate_input),
    .safety_loop_input(safety_loop_input), .meas_trig_input(meas_trig_input), .gp_pin_in(gp_pin_in),
    .mains_good_output_in(mains_good_output_in), .alarm_output_in(alarm_output_in));

  ////////////////////////////////////////
  task automatic stop_test();
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] got);
    compares++;
    if (got !== e) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", nm, e, got);
    end
  endtask

  // Request held until pready is sampled high, released at that edge
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    // Only the cycle ceiling ends a wait that never sees pready
    do begin
      @(posedge ref_clk);
    end while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic err);
    rq.push_back({err, e});
    apb(1'b0, a, 32'h0000_0000);
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  // Counts trigger, start pulses, pin 1 edges and highs, indicator toggles
  task automatic watch(input int n);
    logic p, l;
    p = gp_pin_in[1];
    l = alarm_led;
    c = '{0, 0, 0, 0, 0};
    repeat (n) begin
      settle(1);
      c[0] += trig_output;
      c[1] += meas_start;
      c[2] += (gp_pin_in[1] && !p);
      c[3] += gp_pin_in[1];
      c[4] += (alarm_led != l);
      p = gp_pin_in[1];
      l = alarm_led;
    end
  endtask

  ////////////////////////////////////////
  always @(posedge ref_clk) begin
    if (psel && penable && pready === 1'b1 && !pwrite) begin
      note = rq.pop_front();
      chk("prdata", note[31:0], prdata);
      chk("pslverr", {31'h0, note[32]}, {31'h0, pslverr});
    end
  end

  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      stop_test();
    end
  end

  ////////////////////////////////////////
  initial begin
    repeat (12) @(posedge ref_clk);
    rst_b <= 1'b1;
    settle(1);
    chk("output_on", 0, output_on);
    chk("gp_pin_oe_b", 0, gp_pin_oe_b);
    rd(CTRL_OFFSET, 0, 1'b0);
    rd(IRQ_STATUS_OFFSET, 0, 1'b0);
    r = $random(seed);
    wr(IRQ_MASK_OFFSET, r);
    rd(IRQ_MASK_OFFSET, r & 32'h0000_03ff, 1'b0);
    // Every function, polarity and contact combination
    for (int i = 0; i < 32; i++) begin
      wr(CTRL_OFFSET, {28'h0, i[2:0], 1'b1});
      ena_open <= i[3];
      loop_open <= i[4];
      settle(5);
      chk("output_on", !(i[0] && (i[3] ^ i[1])) && !(i[2] && i[4]), output_on);
    end
    wr(CTRL_OFFSET, 32'h0000_0003);
    ena_open <= 1'b0;
    loop_open <= 1'b0;
    repeat (5) @(posedge ref_clk);
    ena_open <= 1'b1;
    settle(1);
    chk("output_on", 1, output_on);
    settle(2);
    chk("output_on", 0, output_on);
    @(posedge ref_clk);
    ena_open <= 1'b0;
    settle(5);
    chk("alarm_oe_b", 0, alarm_output_oe_b);
    chk("mains_oe_b", 0, mains_good_output_oe_b);
    wr(IRQ_STATUS_OFFSET, 32'h0000_03ff);
    wr(IRQ_MASK_OFFSET, 32'h0000_0001);
    rd(IRQ_STATUS_OFFSET, 0, 1'b0);
    f = 8'($random(seed)) | 8'h01;
    @(posedge ref_clk);
    fault_in <= f;
    settle(3);
    chk("output_on", 0, output_on);
    chk("mains_oe_b", 1, mains_good_output_oe_b);
    chk("alarm_in", 1, alarm_output_in);
    chk("irq", 1, irq);
    watch(8 * HALF);
    chk("led_toggles", 8, c[4]);
    rd(FAULT_OFFSET, {24'h0, f}, 1'b0);
    rd(IRQ_STATUS_OFFSET, {22'h0, 2'b10, f}, 1'b0);
    wr(IRQ_STATUS_OFFSET, {24'h0, f});
    rd(IRQ_STATUS_OFFSET, 32'h0000_0200, 1'b0);
    settle(1);
    chk("irq", 0, irq);
    @(posedge ref_clk);
    fault_in <= 8'h00;
    settle(3);
    chk("alarm_led", 0, alarm_led);
    chk("mains_oe_b", 0, mains_good_output_oe_b);
    wr(CTRL_OFFSET, 32'h0000_0000);
    settle(2);
    chk("alarm_oe_b", 1, alarm_output_oe_b);
    // Static levels, then a three-pulse train on pin 1
    for (int m = 1; m >= 0; m--) begin
      wr(PIN_BASE_OFFSET, m);
      settle(3);
      chk("pin0", m, gp_pin_in[0]);
    end
    wr(PIN_BASE_OFFSET + PIN_STRIDE + PIN_PERIOD_OFFSET, 32'h0000_0004);
    wr(PIN_BASE_OFFSET + PIN_STRIDE + PIN_HIGH_OFFSET, 32'h0000_0002);
    wr(PIN_BASE_OFFSET + PIN_STRIDE, 32'h0003_0002);
    watch(40);
    chk("pulses", 3, c[2]);
    chk("high_cycles", 6, c[3]);
    // Modes 0 to 3 with the trigger input selected, last one unselected
    for (int m = 0; m < 5; m++) begin
      wr(CTRL_OFFSET, {25'h0, m < 4, m < 4 ? m[1:0] : 2'd2, 4'h1});
      repeat (3) @(posedge ref_clk);
      meas_done <= 1'b1;
      trig_cmd <= 1'b1;
      fork
        watch(12);
        begin
          @(posedge ref_clk);
          meas_done <= 1'b0;
          repeat (4) @(posedge ref_clk);
          trig_cmd <= 1'b0;
        end
      join
      chk("trig_output", m == 1 ? 12 : (m >= 3 ? 0 : 1), c[0]);
      chk("meas_start", m < 4, c[1]);
    end
    wr(12'hffc, 32'hffff_ffff);
    rd(12'hffc, 0, 1'b1);
    settle(2);
    stop_test();
  end
endmodule
